// ==== rtl/mdfm_pkg.sv ====
// shared constants, register map and carrier types of the motor driver fault manager
`default_nettype none
package mdfm_pkg;
   // clock
   localparam int unsigned CLK_NS = 20;
   // apb register map
   localparam int unsigned AW = 12;
   localparam logic [11:0] CFG_OFF = 12'h000;
   localparam logic [11:0] CMD_OFF = 12'h004;
   localparam logic [11:0] STAT_OFF = 12'h008;
   localparam logic [11:0] ACT_OFF = 12'h00C;
   localparam logic [10:0] CFG_RST = 11'h004;
   localparam int unsigned CMD_CLR_BIT = 0;
   // overcurrent deglitch times, one per overcurrent_filter_time code
   localparam int unsigned FILT_W = 8;
   localparam int unsigned OC_FILT0_NS = 200;
   localparam int unsigned OC_FILT1_NS = 500;
   localparam int unsigned OC_FILT2_NS = 1000;
   localparam int unsigned OC_FILT3_NS = 2000;
   localparam logic [7:0] OC_FILT0_CYC = 8'((OC_FILT0_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] OC_FILT1_CYC = 8'((OC_FILT1_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] OC_FILT2_CYC = 8'((OC_FILT2_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] OC_FILT3_CYC = 8'((OC_FILT3_NS + CLK_NS - 1) / CLK_NS);
   // retry interval, two choices
   localparam int unsigned RETRY_W = 20;
   localparam int unsigned RETRY_SHORT_US = 500;
   localparam int unsigned RETRY_LONG_US = 5000;
   localparam int unsigned RETRY_SHORT_CYC = (RETRY_SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RETRY_LONG_CYC = (RETRY_LONG_US * 1000 + CLK_NS - 1) / CLK_NS;
   // power stage
   localparam int unsigned FET_N = 6;
   typedef enum logic [1:0] {
      MDFM_OC_LATCH = 2'b00,
      MDFM_OC_RETRY = 2'b01,
      MDFM_OC_REPORT = 2'b10,
      MDFM_OC_OFF = 2'b11
   } mdfm_oc_mode_t;
   // configuration register fields, bit 0 last
   typedef struct packed {
      logic heat_warning_report_on;
      logic retry_interval;
      logic [1:0] overcurrent_filter_time;
      logic overcurrent_level_sel;
      mdfm_oc_mode_t overcurrent_response_sel;
      logic overvoltage_level_sel;
      logic overvoltage_guard_on;
      logic loop_limit_report_on;
      logic supply_current_cap_on;
   } mdfm_cfg_t;
   // status register fields, bit 0 last
   typedef struct packed {
      logic [5:0] fet_oc_flag;
      logic speed_loop_sat;
      logic current_loop_sat;
      logic bus_current_cap;
      logic control_loop_error_reg;
      logic overheat_shutdown_flag;
      logic overheat_flag;
      logic overcurrent_flag;
      logic overvoltage_flag;
      logic pump_low_flag;
      logic gate_stage_error_flag;
   } mdfm_stat_t;
   // detector outputs arriving from the analog side
   typedef struct packed {
      logic supply_uvlo;
      logic avdd_uv;
      logic buck_uv;
      logic pump_uv;
      logic vm_over_lo;
      logic vm_over_hi;
      logic bus_over;
      logic cur_loop_sat;
      logic spd_loop_sat;
      logic temp_warn;
      logic temp_shut;
   } mdfm_sense_t;
   // actions driven to the power stage
   typedef struct packed {
      logic retry_busy;
      logic logic_reset;
      logic buck_switch_off;
      logic speed_limit;
      logic pump_enable;
      logic fets_enable;
   } mdfm_act_t;
   localparam mdfm_act_t ACT_RST = 6'h0E;
endpackage
`default_nettype wire

// ==== rtl/mdfm_deglitch.sv ====
// two-stage synchroniser plus persistence filter for a comparator pair
`default_nettype none
module mdfm_deglitch (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // raw comparators and choice
   input wire logic [1:0] raw,
   input wire logic sel,
   input wire logic [mdfm_pkg::FILT_W-1:0] limit,
   // filtered result
   output logic hit
);
   import mdfm_pkg::*;
   logic [1:0] meta_q;
   logic [1:0] sync_q;
   logic [FILT_W-1:0] cnt_q;
   logic level;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 2'h0;
         sync_q <= 2'h0;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   assign level = sel ? sync_q[1] : sync_q[0];

   // counter saturates so a long fault never wraps to a clean reading
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
      end else if (!level) begin
         cnt_q <= '0;
      end else if (cnt_q != '1) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // must persist longer than the limit
   assign hit = level && (cnt_q > limit);
endmodule
`default_nettype wire

// ==== rtl/mdfm_retry_timer.sv ====
// one-shot retry interval timer
`default_nettype none
module mdfm_retry_timer (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // control
   input wire logic flush,
   input wire logic start,
   input wire logic [mdfm_pkg::RETRY_W-1:0] length,
   // state
   output logic busy
);
   import mdfm_pkg::*;
   logic [RETRY_W-1:0] left_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         left_q <= '0;
      end else if (flush) begin
         left_q <= '0;
      end else if (start && left_q == '0) begin
         left_q <= length;
      end else if (left_q != '0) begin
         left_q <= left_q - 1'b1;
      end
   end

   assign busy = (left_q != '0);
endmodule
`default_nettype wire

// ==== rtl/mdfm_fault_manager.sv ====
// fault manager top: detector conditioning, fault responses and apb registers
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
module mdfm_fault_manager #(
   parameter int unsigned RETRY_SHORT_CYC = mdfm_pkg::RETRY_SHORT_CYC,
   parameter int unsigned RETRY_LONG_CYC = mdfm_pkg::RETRY_LONG_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mdfm_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog detectors, asynchronous
   input wire mdfm_pkg::mdfm_sense_t sense,
   input wire logic [mdfm_pkg::FET_N-1:0] fet_over_lo,
   input wire logic [mdfm_pkg::FET_N-1:0] fet_over_hi,
   input wire logic buck_hs_over,
   // responses
   output logic fault_out_low,
   output mdfm_pkg::mdfm_act_t drive_q
);
   import mdfm_pkg::*;

   localparam logic [RETRY_W-1:0] RETRY_SHORT = RETRY_W'(RETRY_SHORT_CYC);
   localparam logic [RETRY_W-1:0] RETRY_LONG = RETRY_W'(RETRY_LONG_CYC);

   // detector synchronisers
   mdfm_sense_t sense_meta_q;
   mdfm_sense_t sense_q;

   generate
      for (genvar i = 0; i < $bits(mdfm_sense_t); i++) begin : g_sync
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               sense_meta_q[i] <= 1'b0;
               sense_q[i] <= 1'b0;
            end else begin
               sense_meta_q[i] <= sense[i];
               sense_q[i] <= sense_meta_q[i];
            end
         end
      end
   endgenerate

   // configuration and command state
   mdfm_cfg_t cfg_q;
   logic clr_q;
   mdfm_stat_t stat_q;
   mdfm_stat_t stat_d;
   logic oc_latch_q;
   logic oc_report_q;

   // supply loss or buck overcurrent resets config, status, latches, retry timer and pin, not the bus side
   logic buck_oc_hit;
   logic core_reset;
   logic buck_off;

   assign buck_off = sense_q.buck_uv || buck_oc_hit;
   assign core_reset = sense_q.supply_uvlo || sense_q.avdd_uv || buck_off;

   // overcurrent filtering
   logic [FILT_W-1:0] filt_limit;
   logic [FET_N-1:0] fet_hit;
   logic oc_any;

   always_comb begin
      unique case (cfg_q.overcurrent_filter_time)
         2'h0: filt_limit = OC_FILT0_CYC;
         2'h1: filt_limit = OC_FILT1_CYC;
         2'h2: filt_limit = OC_FILT2_CYC;
         2'h3: filt_limit = OC_FILT3_CYC;
      endcase
   end

   generate
      for (genvar f = 0; f < FET_N; f++) begin : g_fet
         mdfm_deglitch u_fet_filt (
            .clk(clk),
            .arst_n(arst_n),
            .raw({fet_over_hi[f], fet_over_lo[f]}),
            .sel(cfg_q.overcurrent_level_sel),
            .limit(filt_limit),
            .hit(fet_hit[f])
         );
      end
   endgenerate

   // buck high-side switch shares the overcurrent deglitch time
   mdfm_deglitch u_buck_filt (
      .clk(clk),
      .arst_n(arst_n),
      .raw({1'b0, buck_hs_over}),
      .sel(1'b0),
      .limit(filt_limit),
      .hit(buck_oc_hit)
   );

   // mode 11 hides every FET overcurrent event, not the buck switch one
   assign oc_any = (|fet_hit) && (cfg_q.overcurrent_response_sel != MDFM_OC_OFF);

   // one decode per response mode keeps the latches readable
   logic mode_latch;
   logic mode_retry;
   logic mode_report;

   assign mode_latch = (cfg_q.overcurrent_response_sel == MDFM_OC_LATCH);
   assign mode_retry = (cfg_q.overcurrent_response_sel == MDFM_OC_RETRY);
   assign mode_report = (cfg_q.overcurrent_response_sel == MDFM_OC_REPORT);

   // fault conditions
   logic ov_event;
   logic cap_event;
   logic sat_event;
   logic warn_event;
   logic retry_start;
   logic retry_busy;
   logic drv_block;
   logic report_any;
   logic [FET_N-1:0] fet_flag_d;

   assign ov_event = cfg_q.overvoltage_guard_on &&
      (cfg_q.overvoltage_level_sel ? sense_q.vm_over_hi : sense_q.vm_over_lo);
   assign cap_event = cfg_q.supply_current_cap_on && sense_q.bus_over;
   assign sat_event = cfg_q.loop_limit_report_on &&
      (sense_q.cur_loop_sat || sense_q.spd_loop_sat);
   assign warn_event = cfg_q.heat_warning_report_on && sense_q.temp_warn;

   // a new trip is only armed once the previous interval has run out
   assign retry_start = oc_any && mode_retry;

   // flushed on internal reset so no stale interval outlives it
   mdfm_retry_timer u_retry (
      .clk(clk),
      .arst_n(arst_n),
      .flush(core_reset),
      .start(retry_start),
      .length(cfg_q.retry_interval ? RETRY_LONG : RETRY_SHORT),
      .busy(retry_busy)
   );

   // latched shutdown, released by a clear once the current is normal
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oc_latch_q <= 1'b0;
      end else if (core_reset) begin
         oc_latch_q <= 1'b0;
      end else if (oc_any && mode_latch) begin
         oc_latch_q <= 1'b1;
      end else if (clr_q && !oc_any) begin
         oc_latch_q <= 1'b0;
      end
   end

   // report-only keeps driving; the controller must react itself
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oc_report_q <= 1'b0;
      end else if (core_reset) begin
         oc_report_q <= 1'b0;
      end else if (oc_any && mode_report) begin
         oc_report_q <= 1'b1;
      end else if (clr_q && !oc_any) begin
         oc_report_q <= 1'b0;
      end
   end

   // everything that stops the bridge except an internal reset
   assign drv_block = sense_q.pump_uv || ov_event || oc_latch_q || retry_busy ||
      sense_q.temp_shut;

   // every reason the pin is pulled low
   assign report_any = drv_block || oc_report_q || cap_event || sat_event ||
      warn_event;

   // per-FET sticky flags, a set in the clear cycle wins
   generate
      for (genvar f = 0; f < FET_N; f++) begin : g_fet_flag
         assign fet_flag_d[f] = (fet_hit[f] && oc_any) ||
            (stat_q.fet_oc_flag[f] && !clr_q);
      end
   endgenerate

   // status flags: a set in the clear cycle always wins
   always_comb begin
      stat_d = stat_q;
      stat_d.gate_stage_error_flag = drv_block || oc_report_q;
      stat_d.pump_low_flag = sense_q.pump_uv ||
         (stat_q.pump_low_flag && !clr_q);
      stat_d.overvoltage_flag = ov_event ||
         (stat_q.overvoltage_flag && !clr_q);
      stat_d.overcurrent_flag = oc_any ||
         (stat_q.overcurrent_flag && !clr_q);
      stat_d.fet_oc_flag = fet_flag_d;
      stat_d.overheat_flag = warn_event ||
         (stat_q.overheat_flag && !(clr_q && !sense_q.temp_warn));
      stat_d.overheat_shutdown_flag = sense_q.temp_shut ||
         (stat_q.overheat_shutdown_flag && !clr_q);
      stat_d.bus_current_cap = cap_event;
      stat_d.current_loop_sat = cfg_q.loop_limit_report_on && sense_q.cur_loop_sat;
      stat_d.speed_loop_sat = cfg_q.loop_limit_report_on && sense_q.spd_loop_sat;
      stat_d.control_loop_error_reg = cap_event || sat_event;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stat_q <= '0;
      end else if (core_reset) begin
         stat_q <= '0;
      end else begin
         stat_q <= stat_d;
      end
   end

   // fault pin follows every active report
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_out_low <= 1'b1;
      end else if (core_reset) begin
         fault_out_low <= 1'b1;
      end else begin
         fault_out_low <= !report_any;
      end
   end

   // power stage actions
   // the pump only stops for overheat, supply loss or buck switch overcurrent, never for FET overcurrent
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_q <= ACT_RST;
      end else begin
         drive_q.fets_enable <= !core_reset && !drv_block;
         drive_q.pump_enable <= !core_reset && !sense_q.temp_shut;
         drive_q.speed_limit <= !core_reset && cap_event;
         drive_q.buck_switch_off <= buck_off;
         drive_q.logic_reset <= core_reset;
         drive_q.retry_busy <= retry_busy;
      end
   end

   // apb: one wait state so every answer comes from a flop
   logic acc;
   logic hit_cfg;
   logic hit_cmd;
   logic hit_stat;
   logic hit_act;
   logic mapped;
   logic [31:0] rd_d;

   assign acc = psel && penable && !pready;
   assign hit_cfg = (paddr == CFG_OFF);
   assign hit_cmd = (paddr == CMD_OFF);
   assign hit_stat = (paddr == STAT_OFF);
   assign hit_act = (paddr == ACT_OFF);
   assign mapped = hit_cfg || hit_cmd || hit_stat || hit_act;

   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit_cfg) begin
         rd_d[$bits(mdfm_cfg_t)-1:0] = cfg_q;
      end else if (hit_stat) begin
         rd_d[$bits(mdfm_stat_t)-1:0] = stat_q;
      end else if (hit_act) begin
         rd_d[$bits(mdfm_act_t)-1:0] = drive_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= acc;
      end
   end

   // unmapped offsets answer with an error and no effect
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= acc && !mapped;
      end
   end

   // read data stands only in the answer cycle, zero otherwise
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= (acc && !pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   // writes take effect on the edge that samples pready high
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= CFG_RST;
      end else if (core_reset) begin
         cfg_q <= CFG_RST;
      end else if (psel && penable && pready && pwrite && hit_cfg) begin
         cfg_q <= pwdata[$bits(mdfm_cfg_t)-1:0];
      end
   end

   // clear command is a one-cycle pulse
   // flags see it one edge after the write, so a set in that edge still wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clr_q <= 1'b0;
      end else begin
         clr_q <= psel && penable && pready && pwrite && hit_cmd &&
            pwdata[CMD_CLR_BIT];
      end
   end
endmodule
`default_nettype wire

// ==== sim/mdfm_fault_manager_checker.sv ====
// port checker for the fault manager, bound to its top
`default_nettype none
module mdfm_fault_manager_checker import mdfm_pkg::*; #(
   parameter int unsigned RETRY_SHORT_CYC = 20,
   parameter int unsigned RETRY_LONG_CYC = 40
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // bus answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // detectors
   input wire mdfm_pkg::mdfm_sense_t sense,
   input wire logic buck_hs_over,
   // responses
   input wire logic fault_out_low,
   input wire mdfm_pkg::mdfm_act_t drive_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic calm;
   logic [7:0] hs_cnt_q;
   // any reset source overrides the pin, so pin checks need none of them
   assign calm = !(sense.supply_uvlo || sense.avdd_uv || sense.buck_uv || buck_hs_over);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) hs_cnt_q <= 8'h00;
      else if (!buck_hs_over) hs_cnt_q <= 8'h00;
      else if (hs_cnt_q != 8'hFF) hs_cnt_q <= hs_cnt_q + 8'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
   chk_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
   chk_pump_fets_off: assert property ((calm && sense.pump_uv) [*3] |-> ##2
      (!drive_q.fets_enable && !fault_out_low)) else $error("pump fault not acted on");
   chk_uvlo_reset_all: assert property (sense.supply_uvlo [*3] |-> ##2
      (drive_q.logic_reset && !drive_q.fets_enable && !drive_q.pump_enable && fault_out_low))
      else $error("supply lockout not reset");
   chk_avdd_reset_all: assert property (sense.avdd_uv [*3] |-> ##2
      (drive_q.logic_reset && !drive_q.fets_enable && !drive_q.pump_enable))
      else $error("regulator lockout not reset");
   chk_buck_uv_off: assert property (sense.buck_uv [*3] |-> ##2
      (drive_q.logic_reset && drive_q.buck_switch_off)) else $error("buck lockout missed");
   chk_shut_all_off: assert property ((calm && sense.temp_shut) [*3] |-> ##2
      (!drive_q.fets_enable && !drive_q.pump_enable && !fault_out_low))
      else $error("overheat shutdown missed");
   chk_buck_oc_reset: assert property (hs_cnt_q == 8'h78 |->
      (drive_q.logic_reset && drive_q.buck_switch_off)) else $error("buck overcurrent missed");
   chk_retry_fets_off: assert property (drive_q.retry_busy |->
      !drive_q.fets_enable) else $error("fets on during retry");
endmodule
bind mdfm_fault_manager mdfm_fault_manager_checker #(.RETRY_SHORT_CYC(RETRY_SHORT_CYC),
   .RETRY_LONG_CYC(RETRY_LONG_CYC)) u_chk (.clk(clk), .arst_n(arst_n), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sense(sense), .buck_hs_over(buck_hs_over),
   .fault_out_low(fault_out_low), .drive_q(drive_q));
`default_nettype wire

// ==== sim/mdfm_ctrl_model.sv ====
// external controller model watching the fault pin
`default_nettype none
module mdfm_ctrl_model (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // watched pin and mode
   input wire logic fault_out_low,
   input wire logic report_mode,
   // protective action
   output logic stop_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // in report-only mode the device keeps driving, so stopping is ours to do
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) stop_req <= 1'b0;
      else stop_req <= report_mode && !fault_out_low;
   end
endmodule
`default_nettype wire

// ==== sim/tb_motor_driver_fault_manager.sv ====
// self-checking bench for the fault manager
`default_nettype none
module tb_motor_driver_fault_manager;
   timeunit 1ns;
   timeprecision 1ps;
   import mdfm_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, report_mode = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, fault_out_low, stop_req, er;
   mdfm_sense_t sense = '0;
   logic [5:0] fet_lo = 6'h00, fet_hi = 6'h00;
   logic buck_hs_over = 1'b0;
   mdfm_act_t drive_q;
   int num_errors = 0, tests_run = 0, seed = 32'h1826410d, k, m, lim;
   logic [31:0] fet_bit;
   initial forever #10 clk = ~clk;
   mdfm_fault_manager #(.RETRY_SHORT_CYC(20), .RETRY_LONG_CYC(40)) dut (.clk(clk),
      .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
      .fet_over_lo(fet_lo), .fet_over_hi(fet_hi), .buck_hs_over(buck_hs_over),
      .fault_out_low(fault_out_low), .drive_q(drive_q));
   mdfm_ctrl_model u_ctrl (.clk(clk), .arst_n(arst_n), .fault_out_low(fault_out_low),
      .report_mode(report_mode), .stop_req(stop_req));
   task test_done;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         chk("pready", 32'h1, 32'h0);
         test_done();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   task pins(input logic p, input logic [5:0] e, input logic [5:0] mask);
      chk("fault_out_low", {31'h0, p}, {31'h0, fault_out_low});
      chk("drive_q", {26'h0, e}, {26'h0, drive_q & mask});
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one detector raised, checked, dropped, then the sticky bits cleared
   task step(input int b, input logic [31:0] cfg, input logic p1, input logic [5:0] mask,
         input logic [5:0] a1, input logic [31:0] s1, input logic [31:0] s0);
      apb(1'b1, CFG_OFF, cfg);
      sense[b] <= 1'b1;
      wt(6);
      pins(p1, a1, mask);
      rdchk("stat_on", STAT_OFF, s1);
      sense[b] <= 1'b0;
      wt(6);
      pins(1'b1, 6'h03 & mask, mask);
      rdchk("stat_off", STAT_OFF, s0);
      apb(1'b1, CMD_OFF, 32'h1);
      wt(2);
      rdchk("stat_clr", STAT_OFF, 32'h0);
   endtask
   initial begin
      wt(4);
      arst_n <= 1'b1;
      wt(2);
      pins(1'b1, 6'h03, 6'h3F);
      rdchk("cfg_rst", CFG_OFF, {21'h0, CFG_RST});
      apb(1'b0, 12'hFF0, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      apb(1'b1, STAT_OFF, 32'hFFFF);
      rdchk("stat_ro", STAT_OFF, 32'h0);
      step(7, 32'h4, 1'b0, 6'h01, 6'h00, 32'h3, 32'h2);
      step(6, 32'h4, 1'b0, 6'h01, 6'h00, 32'h5, 32'h4);
      step(5, 32'h4, 1'b1, 6'h01, 6'h01, 32'h0, 32'h0);
      step(5, 32'hC, 1'b0, 6'h01, 6'h00, 32'h5, 32'h4);
      step(6, 32'h0, 1'b1, 6'h01, 6'h01, 32'h0, 32'h0);
      step(4, 32'h5, 1'b0, 6'h05, 6'h05, 32'hC0, 32'h0);
      step(3, 32'h6, 1'b0, 6'h01, 6'h01, 32'h140, 32'h0);
      step(2, 32'h6, 1'b0, 6'h01, 6'h01, 32'h240, 32'h0);
      step(1, 32'h4, 1'b1, 6'h01, 6'h01, 32'h0, 32'h0);
      step(1, 32'h404, 1'b0, 6'h01, 6'h01, 32'h10, 32'h10);
      step(0, 32'h4, 1'b0, 6'h03, 6'h00, 32'h21, 32'h20);
      for (m = 0; m < 4; m++) begin
         k = {$random(seed)} % 6;
         fet_bit = 32'h1 << (10 + k);
         report_mode <= (m == 2);
         apb(1'b1, CFG_OFF, 32'h4 | (m << 4));
         fet_lo[k] <= 1'b1;
         wt(5);
         fet_lo[k] <= 1'b0;
         wt(20);
         rdchk("oc_glitch", STAT_OFF, 32'h0);
         fet_lo[k] <= 1'b1;
         wt(18);
         pins(m == 3, {m == 1, 4'h0, m > 1}, 6'h21);
         rdchk("oc_on", STAT_OFF, (m < 3) ? (32'h9 | fet_bit) : 32'h0);
         fet_lo[k] <= 1'b0;
         wt(40);
         pins(!(m == 0 || m == 2), {5'h0, m != 0}, 6'h01);
         chk("stop_req", {31'h0, m == 2}, {31'h0, stop_req});
         apb(1'b0, STAT_OFF, 32'h0);
         chk("oc_off", (m < 3) ? (fet_bit | 32'h8 | (m != 1)) : 32'h0, rd);
         apb(1'b1, CMD_OFF, 32'h1);
         wt(3);
         pins(1'b1, 6'h03, 6'h03);
         rdchk("oc_clr", STAT_OFF, 32'h0);
      end
      // high trip level, random deglitch code, long retry interval
      k = {$random(seed)} % 6;
      m = {$random(seed)} % 4;
      fet_bit = 32'h1 << (10 + k);
      lim = (m == 0) ? OC_FILT0_CYC : (m == 1) ? OC_FILT1_CYC : (m == 2) ? OC_FILT2_CYC :
         OC_FILT3_CYC;
      apb(1'b1, CFG_OFF, 32'h254 | (m << 7));
      fet_lo[k] <= 1'b1;
      wt(110);
      rdchk("oc_lo_ignored", STAT_OFF, 32'h0);
      fet_lo[k] <= 1'b0;
      fet_hi[k] <= 1'b1;
      wt(lim + 5);
      pins(1'b1, 6'h01, 6'h21);
      wt(1);
      pins(1'b0, 6'h20, 6'h21);
      fet_hi[k] <= 1'b0;
      wt(39);
      pins(1'b0, 6'h20, 6'h21);
      wt(1);
      pins(1'b1, 6'h01, 6'h21);
      rdchk("oc_retry_end", STAT_OFF, 32'h8 | fet_bit);
      apb(1'b1, CMD_OFF, 32'h1);
      wt(2);
      rdchk("oc_hi_clr", STAT_OFF, 32'h0);
      for (k = 8; k < 11; k++) begin
         apb(1'b1, CFG_OFF, {$random(seed)} & 32'h7FF);
         sense[k] <= 1'b1;
         wt(6);
         pins(1'b1, (k == 8) ? 6'h18 : 6'h10, (k == 8) ? 6'h1B : 6'h13);
         sense[k] <= 1'b0;
         wt(6);
         rdchk("cfg_lost", CFG_OFF, {21'h0, CFG_RST});
      end
      buck_hs_over <= 1'b1;
      wt(130);
      pins(1'b1, 6'h18, 6'h1B);
      buck_hs_over <= 1'b0;
      wt(8);
      pins(1'b1, 6'h03, 6'h1B);
      test_done();
   end
endmodule
`default_nettype wire
